// ---- src/isa_pnp_card.sv ----
// Added by the designer: the address map and the APB register port.
`include "pnp_defines.svh"
module isa_pnp_card
   import pnp_pkg::*;
(
   input wire logic pclk, // Bus clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   output logic [5:0] ld_addr, // Load store address
   input wire logic [7:0] ld_data, // Load store data
   input wire logic other_drive, // Another card drives isolation data
   output logic [7:0] auto_cfg, // Auto-configuration value
   output logic [7:0] rd_port, // Read-data port address
   output logic irq // Interrupt, level
);

   ////////////////////////////////////////////////////////////////
   // Declarations
   state_t state_q;
   logic [7:0] mem [0:63];
   logic [5:0] ld_cnt_q;
   logic [7:0] csn_q;
   logic [7:0] idx_q;
   logic [7:0] key_exp_q;
   logic [5:0] key_cnt_q;
   logic [6:0] ptr_q;
   logic [2:0] bit_q;
   logic half_q;
   logic ready_q;
   logic fill_q;
   logic [7:0] auto_cfg_q;
   logic [7:0] rd_port_q;
   logic [`INT_W-1:0] int_stat_q;
   logic [`INT_W-1:0] int_mask_q;
   logic [`INT_W-1:0] events;
   logic [31:0] prdata_q;
   logic od_meta_q, od_sync_q;
   logic wr_acc, rd_acc, rd_setup;
   logic active;
   logic key_ok;
   logic wr_addr, wr_data;
   logic cmd_wake, cmd_csn, cmd_rdp, cmd_ctl;
   logic ctl_reset, ctl_wfk, ctl_rst_csn;
   logic rd_iso, rd_res;
   logic iso_lose;
   logic load_done;
   logic [7:0] cur_byte;
   logic cur_bit;
   logic [7:0] wd8;

   ////////////////////////////////////////////////////////////////
   // Helpers

   // Key sequence generator step
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[0] ^ v[1], v[7:1]};
   endfunction

   // Address decode shared by write path and error answer
   function automatic logic mapped(input logic [11:0] a);
      return a == `OFS_ADDR || a == `OFS_WDATA || a == `OFS_RDATA ||
         a == `OFS_STATE || a == `OFS_INT_STAT || a == `OFS_INT_MASK ||
         a == `OFS_RD_PORT;
   endfunction

   ////////////////////////////////////////////////////////////////
   // Bus decode

   // Zero-wait slave; effects land at the access edge only
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   assign wr_acc = psel && penable && pwrite && mapped(paddr);
   assign rd_acc = psel && penable && !pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign wd8 = pwdata[7:0];
   assign wr_addr = wr_acc && paddr == `OFS_ADDR;
   assign wr_data = wr_acc && paddr == `OFS_WDATA;
   // ports closed while waiting for key or loading
   assign active = state_q != st_wait_key && state_q != st_load;
   assign cmd_wake = wr_data && active && idx_q == `IDX_WAKE;
   assign cmd_csn = wr_data && state_q == st_isolate && idx_q == `IDX_CSN;
   assign cmd_rdp = wr_data && state_q == st_isolate && idx_q == `IDX_RD_PORT;
   assign cmd_ctl = wr_data && active && idx_q == `IDX_CFG_CTL;
   assign ctl_reset = cmd_ctl && wd8[`CTL_RESET];
   assign ctl_wfk = cmd_ctl && wd8[`CTL_WFK];
   assign ctl_rst_csn = cmd_ctl && wd8[`CTL_RST_CSN];
   assign rd_iso = rd_acc && paddr == `OFS_RDATA && state_q == st_isolate &&
      idx_q == `IDX_ISO;
   // resource reads count only in Configuration
   assign rd_res = rd_acc && paddr == `OFS_RDATA && state_q == st_config &&
      idx_q == `IDX_RES && ready_q;

   // one pointer feeds identifier and resource bytes
   assign cur_byte = mem[6'(ptr_q - `PTR_START)];
   assign cur_bit = cur_byte[bit_q];
   // a zero bit while another card drives means this card lost
   assign iso_lose = rd_iso && !half_q && !cur_bit && od_sync_q;
   assign load_done = state_q == st_load && ld_cnt_q == `SRAM_LAST;

   ////////////////////////////////////////////////////////////////
   // Pin synchroniser for the shared isolation data line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         od_meta_q <= 1'b0;
         od_sync_q <= 1'b0;
      end else begin
         od_meta_q <= other_drive;
         od_sync_q <= od_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Power-up load of the internal store

   // copy one byte a cycle from the load source
   always_ff @(posedge pclk) begin
      if (state_q == st_load) begin
         mem[ld_cnt_q] <= ld_data;
      end
   end

   // Load counter restarts on every reset command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ld_cnt_q <= 6'h00;
      end else if (ctl_reset || state_q != st_load) begin
         ld_cnt_q <= 6'h00;
      end else begin
         ld_cnt_q <= ld_cnt_q + 6'h01;
      end
   end
   assign ld_addr = ld_cnt_q;

   // auto-config taken while loading, applied at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto_cfg_q <= 8'h00;
      end else if (state_q == st_load && ld_cnt_q == `AUTOCFG_IDX) begin
         auto_cfg_q <= ld_data;
      end
   end
   assign auto_cfg = auto_cfg_q;

   ////////////////////////////////////////////////////////////////
   // Initiation key detector

   // compare each address write, restart on mismatch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_exp_q <= `KEY_SEED;
         key_cnt_q <= 6'h00;
      end else if (state_q != st_wait_key || key_ok) begin
         key_exp_q <= `KEY_SEED;
         key_cnt_q <= 6'h00;
      end else if (wr_addr) begin
         if (wd8 == key_exp_q) begin
            key_exp_q <= lfsr_next(key_exp_q);
            key_cnt_q <= key_cnt_q + 6'h01;
         end else if (wd8 == `KEY_SEED) begin
            // Mismatch that is itself a fresh start
            key_exp_q <= lfsr_next(`KEY_SEED);
            key_cnt_q <= 6'h01;
         end else begin
            key_exp_q <= `KEY_SEED;
            key_cnt_q <= 6'h00;
         end
      end
   end
   assign key_ok = state_q == st_wait_key && wr_addr && wd8 == key_exp_q &&
      key_cnt_q == `KEY_LAST;

   // Register index behind the address port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_q <= `IDX_RD_PORT;
      end else if (wr_addr && active) begin
         idx_q <= wd8;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Card state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= st_load;
      end else if (ctl_reset) begin
         state_q <= st_load;
      end else if (ctl_wfk) begin
         state_q <= st_wait_key;
      end else begin
         unique case (state_q)
            st_load: if (load_done) state_q <= st_wait_key;
            st_wait_key: if (key_ok) state_q <= st_sleep;
            st_sleep, st_isolate, st_config: begin
               if (cmd_wake) begin
                  if (wd8 == csn_q) begin
                     state_q <= (wd8 == 8'h00) ? st_isolate : st_config;
                  end else begin
                     state_q <= st_sleep;
                  end
               end else if (cmd_csn) begin
                  state_q <= st_config;
               end else if (iso_lose) begin
                  state_q <= st_sleep;
               end
            end
         endcase
      end
   end

   // CSN cleared at power-on reset and by the reset-CSN command, not by the reset command; stored on assignment
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csn_q <= 8'h00;
      end else if (ctl_rst_csn) begin
         csn_q <= 8'h00;
      end else if (cmd_csn) begin
         csn_q <= wd8;
      end
   end

   // read-data port address kept for the host side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_port_q <= 8'h00;
      end else if (cmd_rdp) begin
         rd_port_q <= wd8;
      end
   end
   assign rd_port = rd_port_q;

   ////////////////////////////////////////////////////////////////
   // Shared data pointer and isolation bit walk

   // reset and every Wake return the pointer to start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_q <= `PTR_START;
         bit_q <= 3'h0;
         half_q <= 1'b0;
      end else if (cmd_wake || ctl_reset) begin
         ptr_q <= `PTR_START;
         bit_q <= 3'h0;
         half_q <= 1'b0;
      end else if (rd_iso) begin
         // walking all identifier bytes leaves pointer on resources
         half_q <= !half_q;
         if (half_q) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) ptr_q <= ptr_q + 7'h01;
         end
      end else if (rd_res) begin
         // after Wake the identifier bytes come out first
         ptr_q <= ptr_q + 7'h01;
      end
   end

   // read clears ready, next byte shifted in, ready set again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_q <= 1'b0;
         fill_q <= 1'b1;
      end else begin
         fill_q <= rd_res;
         if (rd_res) begin
            ready_q <= 1'b0;
         end else if (fill_q) begin
            ready_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Interrupts

   // Sticky events; set wins over a same-cycle clear
   assign events = {4'(load_done) << `INT_LOADED} | {4'(iso_lose) << `INT_LOST} |
      {4'(cmd_csn) << `INT_WIN} | {4'(key_ok) << `INT_KEY};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_q <= '0;
      end else begin
         int_stat_q <= (int_stat_q & ~((wr_acc && paddr == `OFS_INT_STAT) ?
            pwdata[`INT_W-1:0] : '0)) | events;
      end
   end

   // Mask register, one enables the line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask_q <= '0;
      end else if (wr_acc && paddr == `OFS_INT_MASK) begin
         int_mask_q <= pwdata[`INT_W-1:0];
      end
   end
   assign irq = |(int_stat_q & int_mask_q);

   ////////////////////////////////////////////////////////////////
   // Read data, captured in the setup phase

   // Card read port; quiet cards return zero
   function automatic logic [7:0] card_read(input state_t s);
      logic [7:0] v;
      v = 8'h00;
      if (s == st_isolate && idx_q == `IDX_ISO) begin
         v = cur_bit ? (half_q ? `ISO_ONE_B : `ISO_ONE_A) : 8'h00;
      end else if (s == st_config) begin
         // resource and status only in Configuration
         if (idx_q == `IDX_RES) v = cur_byte;
         if (idx_q == `IDX_STATUS) v = {7'h00, ready_q};
         if (idx_q == `IDX_CSN) v = csn_q;
      end
      return v;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (rd_setup) begin
         unique case (paddr)
            `OFS_ADDR: prdata_q <= {24'h00_0000, idx_q};
            `OFS_RDATA: prdata_q <= {24'h00_0000, card_read(state_q)};
            `OFS_STATE: prdata_q <= {21'h00_0000, csn_q, state_q};
            `OFS_INT_STAT: prdata_q <= {28'h000_0000, int_stat_q};
            `OFS_INT_MASK: prdata_q <= {28'h000_0000, int_mask_q};
            `OFS_RD_PORT: prdata_q <= {24'h00_0000, rd_port_q};
            default: prdata_q <= 32'h0000_0000;
         endcase
      end else if (psel && !penable) begin
         // Writes answer zero, so no stale read data shows
         prdata_q <= 32'h0000_0000;
      end
   end
   assign prdata = prdata_q;

endmodule // isa_pnp_card

// ---- src/pnp_defines.svh ----
`ifndef PNP_DEFINES_SVH
`define PNP_DEFINES_SVH
// APB byte offsets
`define OFS_ADDR 12'h000
`define OFS_WDATA 12'h004
`define OFS_RDATA 12'h008
`define OFS_STATE 12'h00c
`define OFS_INT_STAT 12'h010
`define OFS_INT_MASK 12'h014
`define OFS_RD_PORT 12'h018
// Card register indices behind the address port
`define IDX_RD_PORT 8'h00
`define IDX_ISO 8'h01
`define IDX_CFG_CTL 8'h02
`define IDX_WAKE 8'h03
`define IDX_RES 8'h04
`define IDX_STATUS 8'h05
`define IDX_CSN 8'h06
// Config control bit positions
`define CTL_RESET 0
`define CTL_WFK 1
`define CTL_RST_CSN 2
// Initiation key
`define KEY_SEED 8'h6a
`define KEY_LAST 6'h1f
// Data pointer and internal store
`define PTR_START 7'h01
`define SRAM_LAST 6'h3f
`define AUTOCFG_IDX 6'h3f
// Isolation drive patterns
`define ISO_ONE_A 8'h55
`define ISO_ONE_B 8'haa
// Interrupt status bit positions
`define INT_KEY 0
`define INT_WIN 1
`define INT_LOST 2
`define INT_LOADED 3
`define INT_W 4
`endif

// ---- src/pnp_pkg.sv ----
package pnp_pkg;
   // Card state
   typedef enum logic [2:0] {
      st_load,
      st_wait_key,
      st_sleep,
      st_isolate,
      st_config
   } state_t;
endpackage

// ---- tb/isa_pnp_card_bench.sv ----
`include "pnp_defines.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; \
   $display("ERROR %s exp %0h got %0h", n, (e), (s)); end end
module isa_pnp_card_bench import pnp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, other_drive = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic pready, pslverr, irq, rerr;
   logic [5:0] ld_addr;
   logic [7:0] ld_data, auto_cfg, rd_port;
   int err_count = 0, check_count = 0;
   // 100 MHz clock
   always #5 pclk = ~pclk;
   isa_pnp_card dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ld_addr(ld_addr), .ld_data(ld_data),
      .other_drive(other_drive), .auto_cfg(auto_cfg), .rd_port(rd_port), .irq(irq));
   pnp_store_model u_store (.ld_addr(ld_addr), .ld_data(ld_data));
   ////////////////////////////////////////////////////////////////
   task end_sim;
      $display("Checks %0d, errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // One APB transfer; an idle edge after it so no signal is set twice
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         end_sim();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task cw(input logic [7:0] i, input logic [7:0] v);
      apb(1'b1, `OFS_ADDR, {24'h0000_00, i});
      apb(1'b1, `OFS_WDATA, {24'h0000_00, v});
   endtask
   task cr(input logic [7:0] i);
      apb(1'b1, `OFS_ADDR, {24'h0000_00, i});
      apb(1'b0, `OFS_RDATA, 32'h0000_0000);
   endtask
   task chk_st(input state_t s, input logic [7:0] c);
      apb(1'b0, `OFS_STATE, 32'h0000_0000);
      `CHK("state", {c, s}, rdat[10:0])
   endtask
   // Key bytes from the seed; each next byte shifts in bit0 xor bit1
   task key(input int n);
      logic [7:0] v;
      v = `KEY_SEED;
      for (int i = 0; i < n; i++) begin
         apb(1'b1, `OFS_ADDR, {24'h0000_00, v});
         v = {v[1] ^ v[0], v[7:1]};
      end
   endtask
   // Poll ready, then take one byte; polls are bounded
   task res_byte(input logic [7:0] e);
      int n;
      n = 0;
      do begin
         cr(`IDX_STATUS);
         n++;
      end while (rdat[0] !== 1'b1 && n < 10);
      `CHK("ready", 1'b1, rdat[0])
      cr(`IDX_RES);
      `CHK("res", e, rdat[7:0])
   endtask
   ////////////////////////////////////////////////////////////////
   task t_load;
      int n;
      n = 0;
      // no card access before load ends
      do begin
         apb(1'b0, `OFS_STATE, 32'h0000_0000);
         n++;
      end while (rdat[2:0] !== st_wait_key && n < 40);
      chk_st(st_wait_key, 8'h00);
      `CHK("auto_cfg", 8'hbf, auto_cfg)
   endtask
   task t_locked;
      cw(`IDX_WAKE, 8'h00);
      chk_st(st_wait_key, 8'h00);
   endtask
   task t_key;
      key(31);
      apb(1'b1, `OFS_ADDR, 32'h0000_0000);
      chk_st(st_wait_key, 8'h00);
      key(32);
      chk_st(st_sleep, 8'h00);
   endtask
   // Full isolation: 72 pairs walk bytes 0..8 low bit first
   task t_iso;
      logic [7:0] b;
      cw(`IDX_WAKE, 8'h00);
      chk_st(st_isolate, 8'h00);
      cw(`IDX_RD_PORT, 8'h5b);
      `CHK("rd_port", 8'h5b, rd_port)
      apb(1'b0, `OFS_RD_PORT, 32'h0000_0000);
      `CHK("rd_port_rd", 8'h5b, rdat[7:0])
      apb(1'b1, `OFS_ADDR, {24'h0000_00, `IDX_ISO});
      for (int j = 0; j < 72; j++) begin
         b = {2'b10, 6'(j / 8)};
         apb(1'b0, `OFS_RDATA, 32'h0000_0000);
         `CHK("iso_a", (b[j % 8] ? 8'h55 : 8'h00), rdat[7:0])
         apb(1'b0, `OFS_RDATA, 32'h0000_0000);
         `CHK("iso_b", (b[j % 8] ? 8'haa : 8'h00), rdat[7:0])
      end
      chk_st(st_isolate, 8'h00);
      cw(`IDX_CSN, 8'h03);
      chk_st(st_config, 8'h03);
   endtask
   task t_res;
      res_byte(8'h89);
      res_byte(8'h8a);
   endtask
   task t_wake;
      cw(`IDX_WAKE, 8'h00);
      chk_st(st_sleep, 8'h03);
      cw(`IDX_WAKE, 8'h03);
      chk_st(st_config, 8'h03);
      res_byte(8'h80);
   endtask
   // Losing card, then its interrupt and an unmapped access
   task t_lose;
      cw(`IDX_CFG_CTL, 8'h04);
      cw(`IDX_WAKE, 8'h00);
      chk_st(st_isolate, 8'h00);
      other_drive <= 1'b1;
      repeat (2) @(posedge pclk);
      cr(`IDX_ISO);
      `CHK("iso_lost", 8'h00, rdat[7:0])
      chk_st(st_sleep, 8'h00);
      other_drive <= 1'b0;
      cr(`IDX_RES);
      `CHK("res_quiet", 8'h00, rdat[7:0])
      apb(1'b0, `OFS_INT_STAT, 32'h0000_0000);
      `CHK("int_stat", 4'hf, rdat[3:0])
      `CHK("irq_off", 1'b0, irq)
      apb(1'b1, `OFS_INT_MASK, 32'h0000_0004);
      `CHK("irq_on", 1'b1, irq)
      apb(1'b1, `OFS_INT_STAT, 32'h0000_0004);
      `CHK("irq_clr", 1'b0, irq)
      apb(1'b0, 12'h01c, 32'h0000_0000);
      `CHK("slverr", 1'b1, rerr)
   endtask
   // Control commands: back to key wait, then a full reload
   task t_ctl;
      cw(`IDX_CFG_CTL, 8'h02);
      chk_st(st_wait_key, 8'h00);
      key(32);
      chk_st(st_sleep, 8'h00);
      cw(`IDX_CFG_CTL, 8'h01);
      t_load();
   endtask
   ////////////////////////////////////////////////////////////////
   // Reset for six edges, then every scenario in order
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_load();
      t_locked();
      t_key();
      t_iso();
      t_res();
      t_wake();
      t_lose();
      t_ctl();
      end_sim();
   end
endmodule // isa_pnp_card_bench

// ---- tb/isa_pnp_card_checker.sv ----
`include "pnp_defines.svh"
module isa_pnp_card_checker (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, low
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Write
   input wire logic [11:0] paddr, // Address
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic [5:0] ld_addr, // Store address
   input wire logic [7:0] ld_data, // Store data
   input wire logic [7:0] auto_cfg, // Auto config
   input wire logic [7:0] rd_port, // Read port
   input wire logic irq // Interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic acc;
   logic wcmd;
   logic wint;
   ////////////////////////////////////////////////////////////////
   // Access phase and write decodes, kept as signals for $past
   assign acc = psel && penable;
   assign wcmd = acc && pwrite && paddr == `OFS_WDATA;
   assign wint = acc && pwrite && (paddr == `OFS_INT_STAT || paddr == `OFS_INT_MASK);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////
   property p_rdy;
      pready;
   endproperty
   a_rdy: assert property (p_rdy) else $error("pready low");
   property p_err_hi;
      acc && paddr > `OFS_RD_PORT |-> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_err_hi: assert property (p_err_hi) else $error("unmapped not refused");
   property p_err_lo;
      !acc || paddr <= `OFS_RD_PORT && paddr[1:0] == 2'b00 |-> !pslverr;
   endproperty
   a_err_lo: assert property (p_err_lo) else $error("spurious pslverr");
   property p_ld_inc;
      ld_addr != 6'h00 && ld_addr != 6'h3f |=> ld_addr == $past(ld_addr) + 6'h01;
   endproperty
   a_ld_inc: assert property (p_ld_inc) else $error("load walk broken");
   property p_acfg;
      ld_addr == 6'h3f |=> auto_cfg == $past(ld_data);
   endproperty
   a_acfg: assert property (p_acfg) else $error("auto config not loaded");
   property p_rdp_chg;
      $changed(rd_port) |-> $past(wcmd);
   endproperty
   a_rdp_chg: assert property (p_rdp_chg) else $error("read port moved alone");
   property p_rdp_rd;
      acc && !pwrite && paddr == `OFS_RD_PORT |-> prdata[7:0] == rd_port;
   endproperty
   a_rdp_rd: assert property (p_rdp_rd) else $error("read port readback");
   property p_irq_fell;
      $fell(irq) |-> $past(wint);
   endproperty
   a_irq_fell: assert property (p_irq_fell) else $error("irq fell alone");
   property p_wr_zero;
      acc && pwrite |-> prdata == 32'h0000_0000;
   endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("prdata on write");
endmodule // isa_pnp_card_checker

bind isa_pnp_card isa_pnp_card_checker u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .ld_addr(ld_addr),
   .ld_data(ld_data), .auto_cfg(auto_cfg), .rd_port(rd_port), .irq(irq));

// ---- tb/pnp_store_model.sv ----
module pnp_store_model (
   input wire logic [5:0] ld_addr, // Byte index
   output logic [7:0] ld_data // Stored byte
);
   timeunit 1ns;
   timeprecision 1ps;
   // store contents
   // Byte i holds 8'h80 plus i, so every byte is told apart
   assign ld_data = {2'b10, ld_addr};
endmodule // pnp_store_model
